//--- eaz_zone_bus.sv
// external async zone bus master: three zones onto a shared 20-bit bus
// assumes one requester (processor or dma) presents a request held until done
//
// Contract
// - each zone drives its own active-low select during its access only
// - read and write lead, active and trail counts set per zone
// - zone option lets a low ready input stretch the active phase
// - timing clock runs at system rate or half, shared by zones
// - cycles start on bus clock rise; events on timing clock ticks
// - zone chooses 16- or 32-bit data; reach unchanged
// - in 32-bit mode lowest address line becomes second write strobe
// - one shared 20-bit address bus qualified by zone select
// - dma and processor both reach all three zones
// - timing clock gated after reset until control bit 12 set
// - gating the timing clock leaves the bus clock running
// - zone 0 keeps write then read in program order
// - zone 7 always mapped, disjoint from zone 6
// - zone 0 at 0x4000 4K words; zones 6,7 at 0x100000, 0x200000
// - timing configuration writes accepted only with protect enable set
// - zone selects are independent, never combined
// - zone 0 drives external 0x00000 to 0x00FFF
// - zones 6 and 7 drive 0x00000 to 0xFFFFF
// - zones 0,6,7 always enabled; other addresses make no access
// - outside zone 0 accesses also run one at a time in program order
module eaz_zone_bus
  import eaz_pkg::*;
#(
  parameter int PCLK_W = 16
)
(
  input  wire logic                CLOCK,
  input  wire logic                SYS_RST,
  input  wire logic                CLK_EN,
  input  wire logic [PCLK_W-1:0]   PERIPH_CLK_CTRL3,
  input  wire logic                TIM_FULL_RATE,
  input  wire logic                XCLK_HALF,
  input  wire logic                XCLK_OFF,
  input  wire logic                PROTECT_WR_EN,
  input  wire logic                CFG_WE,
  input  wire logic [1:0]          CFG_ZONE,
  input  wire eaz_timing_t         CFG_TIMING,
  input  wire logic                CPU_VALID,
  input  wire eaz_req_t            CPU_REQ,
  output logic                     CPU_READY,
  input  wire logic                DMA_VALID,
  input  wire eaz_req_t            DMA_REQ,
  output logic                     DMA_READY,
  output logic [DATA_W-1:0]        RDATA,
  output logic                     RDATA_VALID,
  output logic                     REQ_ERROR,
  output logic                     BUSY,
  output logic                     INTERFACE_TIMING_CLOCK,
  output logic                     EXTERNAL_BUS_CLOCK_OUT,
  output logic [ADDR_W-1:0]        EXTERNAL_ADDRESS_BUS,
  output logic                     ZONE0_SELECT_N,
  output logic                     ZONE6_SELECT_N,
  output logic                     ZONE7_SELECT_N,
  output logic                     READ_STROBE_N,
  output logic                     WRITE_STROBE_N,
  output logic [DATA_W-1:0]        DATA_OUT,
  output logic                     DATA_OE,
  input  wire logic [DATA_W-1:0]   DATA_IN,
  input  wire logic                EXTERNAL_READY_INPUT
);
  eaz_timing_t        timing [NZONE];
  eaz_state_t         state;
  eaz_req_t           cur;
  logic [1:0]         zone;
  logic               cur_dma;
  logic [2:0]         pick_dec;
  logic [CNT_W-1:0]   cnt;
  logic               tim_tick;
  logic               xclk_rise;
  logic               rdy_sync;
  logic [DATA_W-1:0]  din_q;
  logic [DATA_W-1:0]  din_sync;
  logic               sel_dma;
  eaz_req_t           pick;
  logic [1:0]         pick_zone;
  logic               pick_hit;
  eaz_phase_t         ph;
  logic               stretch;

  function automatic logic [2:0] zone_decode(input logic [IADDR_W-1:0] a);
    if (a >= ZONE0_BASE && a < ZONE0_BASE + ZONE0_SPAN)
      return {1'b1, 2'(ZONE0_IDX)};
    else if (a >= ZONE6_BASE && a < ZONE6_BASE + ZONE6_SPAN)
      return {1'b1, 2'(ZONE6_IDX)};
    else if (a >= ZONE7_BASE && a < ZONE7_BASE + ZONE7_SPAN)
      return {1'b1, 2'(ZONE7_IDX)};
    else
      return 3'h0;
  endfunction

  function automatic logic [ADDR_W-1:0] ext_addr(input logic [IADDR_W-1:0] a,
                                                 input logic [1:0] z);
    logic [IADDR_W-1:0] off;
    off = 22'h000000;
    case (z)
      2'(ZONE0_IDX): off = a - ZONE0_BASE;
      2'(ZONE6_IDX): off = a - ZONE6_BASE;
      default:       off = a - ZONE7_BASE;
    endcase
    return (z == 2'(ZONE0_IDX)) ? (off[ADDR_W-1:0] & ZONE0_MASK)
                                : (off[ADDR_W-1:0] & ZONE67_MASK);
  endfunction

  eaz_clkgen u_clkgen (
    .clk       (CLOCK),
    .rst       (SYS_RST),
    .en        (CLK_EN),
    .tim_on    (PERIPH_CLK_CTRL3[PCLK_TIMCLK_BIT]),
    .tim_full  (TIM_FULL_RATE),
    .xclk_half (XCLK_HALF),
    .xclk_off  (XCLK_OFF),
    .tim_tick  (tim_tick),
    .xclk_rise (xclk_rise),
    .xclk_out  (EXTERNAL_BUS_CLOCK_OUT)
  );

  assign INTERFACE_TIMING_CLOCK = tim_tick;

  eaz_sync u_rdy (
    .clk  (CLOCK),
    .rst  (SYS_RST),
    .en   (CLK_EN),
    .din  (EXTERNAL_READY_INPUT),
    .dout (rdy_sync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++)
    begin : g_din
      eaz_sync u_d (
        .clk  (CLOCK),
        .rst  (SYS_RST),
        .en   (CLK_EN),
        .din  (DATA_IN[gi]),
        .dout (din_sync[gi])
      );
    end
  endgenerate

  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      for (int i = 0; i < NZONE; i++)
        timing[i] <= TIMING_RESET;
    end
    else if (CLK_EN && CFG_WE && PROTECT_WR_EN && CFG_ZONE < 2'(NZONE))
      timing[CFG_ZONE] <= CFG_TIMING;
  end

  always_comb
  begin
    sel_dma   = DMA_VALID & ~CPU_VALID;
    pick      = sel_dma ? DMA_REQ : CPU_REQ;
    pick_dec  = zone_decode(pick.addr);
    pick_hit  = pick_dec[2];
    pick_zone = pick_dec[1:0];
  end

  always_comb
  begin
    ph      = cur.write ? timing[zone].wr : timing[zone].rd;
    stretch = timing[zone].use_ready & ~rdy_sync;
  end

  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state    <= ST_IDLE;
      cur      <= '0;
      zone     <= 2'h0;
      cur_dma  <= 1'b0;
      cnt      <= CNT_ZERO;
      din_q    <= '0;
    end
    else if (CLK_EN)
    begin
      case (state)
        ST_IDLE:
        begin
          if ((CPU_VALID || DMA_VALID) && pick_hit)
          begin
            cur     <= pick;
            zone    <= pick_zone;
            cur_dma <= sel_dma;
            state   <= ST_START;
          end
        end
        ST_START:
        begin
          if (xclk_rise)
          begin
            cnt   <= ph.lead;
            state <= ST_LEAD;
          end
        end
        ST_LEAD:
        begin
          if (tim_tick)
          begin
            if (cnt <= CNT_ONE)
            begin
              cnt   <= ph.active;
              state <= ST_ACTIVE;
            end
            else
              cnt <= cnt - CNT_ONE;
          end
        end
        ST_ACTIVE:
        begin
          if (tim_tick)
          begin
            if (cnt <= CNT_ONE)
              state <= ST_WAITRD;
            else
              cnt <= cnt - CNT_ONE;
          end
        end
        ST_WAITRD:
        begin
          if (tim_tick && !stretch)
          begin
            din_q <= timing[zone].wide32 ? din_sync
                                         : {{(DATA_W/2){1'b0}}, din_sync[DATA_W/2-1:0]};
            cnt   <= ph.trail;
            state <= ST_TRAIL;
          end
        end
        ST_TRAIL:
        begin
          if (tim_tick)
          begin
            if (cnt <= CNT_ONE)
            begin
              state <= ST_IDLE;
            end
            else
              cnt <= cnt - CNT_ONE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  logic done;
  assign done = CLK_EN & (state == ST_TRAIL) & tim_tick & (cnt <= CNT_ONE);

  assign CPU_READY = (state == ST_IDLE) & CLK_EN & CPU_VALID & ~pick_hit
                     | done & ~cur_dma;
  assign DMA_READY = (state == ST_IDLE) & CLK_EN & sel_dma & ~pick_hit
                     | done & cur_dma;
  assign BUSY      = (state != ST_IDLE);

  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      RDATA_VALID <= 1'b0;
      REQ_ERROR   <= 1'b0;
      RDATA       <= '0;
    end
    else if (CLK_EN)
    begin
      RDATA_VALID <= done & ~cur.write;
      REQ_ERROR   <= (state == ST_IDLE) & (CPU_VALID | DMA_VALID) & ~pick_hit;
      if (done && !cur.write)
        RDATA <= din_q;
    end
  end

  logic in_cycle;
  logic strobe_on;
  assign in_cycle  = (state == ST_LEAD) | (state == ST_ACTIVE) | (state == ST_WAITRD)
                     | (state == ST_TRAIL);
  assign strobe_on = (state == ST_ACTIVE) | (state == ST_WAITRD);

  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      EXTERNAL_ADDRESS_BUS <= '0;
      ZONE0_SELECT_N       <= 1'b1;
      ZONE6_SELECT_N       <= 1'b1;
      ZONE7_SELECT_N       <= 1'b1;
      READ_STROBE_N        <= 1'b1;
      WRITE_STROBE_N       <= 1'b1;
      DATA_OUT             <= '0;
      DATA_OE              <= 1'b0;
    end
    else if (CLK_EN)
    begin
      EXTERNAL_ADDRESS_BUS <= ext_addr(cur.addr, zone);
      if (timing[zone].wide32)
        EXTERNAL_ADDRESS_BUS[0] <= ~(strobe_on & cur.write);
      ZONE0_SELECT_N <= ~(in_cycle & (zone == 2'(ZONE0_IDX)));
      ZONE6_SELECT_N <= ~(in_cycle & (zone == 2'(ZONE6_IDX)));
      ZONE7_SELECT_N <= ~(in_cycle & (zone == 2'(ZONE7_IDX)));
      READ_STROBE_N  <= ~(strobe_on & ~cur.write);
      WRITE_STROBE_N <= ~(strobe_on & cur.write);
      DATA_OUT       <= timing[zone].wide32 ? cur.wdata
                        : {{(DATA_W/2){1'b0}}, cur.wdata[DATA_W/2-1:0]};
      DATA_OE        <= in_cycle & cur.write;
    end
  end
endmodule

//--- eaz_pkg.sv
// package for the external async zone bus: zone map, timing field layout, states
// assumes a 100 MHz system clock and a 20-bit external address bus
package eaz_pkg;
  localparam int ADDR_W      = 20;
  localparam int IADDR_W     = 22;
  localparam int DATA_W      = 32;
  localparam int NZONE       = 3;
  localparam int ZONE0_IDX   = 0;
  localparam int ZONE6_IDX   = 1;
  localparam int ZONE7_IDX   = 2;
  localparam logic [IADDR_W-1:0] ZONE0_BASE = 22'h004000;
  localparam logic [IADDR_W-1:0] ZONE6_BASE = 22'h100000;
  localparam logic [IADDR_W-1:0] ZONE7_BASE = 22'h200000;
  localparam logic [IADDR_W-1:0] ZONE0_SPAN = 22'h001000;
  localparam logic [IADDR_W-1:0] ZONE6_SPAN = 22'h100000;
  localparam logic [IADDR_W-1:0] ZONE7_SPAN = 22'h100000;
  localparam logic [ADDR_W-1:0]  ZONE0_MASK = 20'h00fff;
  localparam logic [ADDR_W-1:0]  ZONE67_MASK = 20'hfffff;
  localparam int PCLK_TIMCLK_BIT = 12;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] LEAD_RESET   = 3'h6;
  localparam logic [CNT_W-1:0] ACTIVE_RESET = 3'h7;
  localparam logic [CNT_W-1:0] TRAIL_RESET  = 3'h3;
  localparam logic [CNT_W-1:0] CNT_ZERO     = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE      = 3'h1;
  localparam logic [1:0] SYNC_ZERO = 2'h0;

  typedef struct packed {
    logic [CNT_W-1:0] lead;
    logic [CNT_W-1:0] active;
    logic [CNT_W-1:0] trail;
  } eaz_phase_t;

  typedef struct packed {
    eaz_phase_t rd;
    eaz_phase_t wr;
    logic       use_ready;
    logic       wide32;
  } eaz_timing_t;

  localparam eaz_timing_t TIMING_RESET =
    '{rd: '{LEAD_RESET, ACTIVE_RESET, TRAIL_RESET},
      wr: '{LEAD_RESET, ACTIVE_RESET, TRAIL_RESET},
      use_ready: 1'b1, wide32: 1'b0};

  typedef struct packed {
    logic [IADDR_W-1:0] addr;
    logic [DATA_W-1:0]  wdata;
    logic               write;
    logic               wide;
  } eaz_req_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_LEAD   = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_WAITRD = 3'b100,
    ST_TRAIL  = 3'b101
  } eaz_state_t;
endpackage

//--- eaz_sync.sv
// three-stage synchroniser for one pin level
// the output is the agreed level of stages two and three
module eaz_sync
  import eaz_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic en,
  input  wire logic din,
  output logic      dout
);
  logic       meta;
  logic [1:0] stage;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta  <= 1'b0;
      stage <= SYNC_ZERO;
      dout  <= 1'b0;
    end
    else if (en)
    begin
      meta  <= din;
      stage <= {stage[0], meta};
      if (stage[1] == stage[0])
        dout <= stage[0];
    end
  end
endmodule

//--- eaz_clkgen.sv
// interface timing clock enable and bus clock out generator
// runs on the system clock; the timing clock is a one-cycle enable tick
module eaz_clkgen
  import eaz_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic en,
  input  wire logic tim_on,
  input  wire logic tim_full,
  input  wire logic xclk_half,
  input  wire logic xclk_off,
  output logic      tim_tick,
  output logic      xclk_rise,
  output logic      xclk_out
);
  logic tdiv;
  logic xdiv;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tdiv <= 1'b0;
    else if (en)
      tdiv <= tim_full ? 1'b0 : ~tdiv;
  end

  assign tim_tick = tim_on & (tim_full | tdiv);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      xdiv <= 1'b0;
    else if (en && (tim_full || tdiv))
      xdiv <= xclk_half ? ~xdiv : 1'b1;
  end

  assign xclk_rise = tim_tick & (~xclk_half | ~xdiv);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      xclk_out <= 1'b0;
    else if (en)
      xclk_out <= ~xclk_off & (xclk_half ? ~xdiv : (tim_full ? ~xclk_out : tdiv));
  end
endmodule

//--- eaz_mem_model.sv
// external memory model on the far side of the zone bus, one bank per zone
// assumes registered strobes and selects held through the trail phase
module eaz_mem_model
  import eaz_pkg::*;
#(
  parameter int WAIT = 12
)
(
  input  wire logic              clk,
  input  wire logic [2:0]        sel_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  input  wire logic [DATA_W-1:0] dout,
  input  wire logic              slow,
  output logic [DATA_W-1:0]      din,
  output logic                   rdy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [512];
  logic [DATA_W-1:0] last = '0;
  logic [8:0]        key;
  logic [1:0]        zc;
  logic              wr_q = 1'b1;
  int                held = 0;
  assign zc = !sel_n[0] ? 2'h0 : (!sel_n[1] ? 2'h1 : 2'h2);
  // address bit 0 left out: it is a strobe in 32-bit mode
  assign key = {zc, addr[7:1]};
  // released bus shows the inverse of the last word
  assign din = (!rd_n && !(&sel_n)) ? mem[key] : ~last;
  assign rdy = !slow || (&sel_n) || held >= WAIT;
  always @(posedge clk)
  begin
    wr_q <= wr_n;
    held <= (&sel_n) ? 0 : held + 1;
    if (!rd_n)
      last <= din;
    if (wr_n && !wr_q && !(&sel_n))
      mem[key] <= dout;
  end
endmodule

//--- eaz_zone_bus_chk.sv
// timing relations of the zone bus pins
// bound into eaz_zone_bus; sees its ports only
module eaz_zone_bus_chk
  import eaz_pkg::*;
#(
  parameter int PCLK_W = 16
)
(
  input wire logic              CLOCK,
  input wire logic              SYS_RST,
  input wire logic [PCLK_W-1:0] PERIPH_CLK_CTRL3,
  input wire logic              TIM_FULL_RATE,
  input wire logic              XCLK_OFF,
  input wire logic              REQ_ERROR,
  input wire logic              INTERFACE_TIMING_CLOCK,
  input wire logic              EXTERNAL_BUS_CLOCK_OUT,
  input wire logic [ADDR_W-1:0] EXTERNAL_ADDRESS_BUS,
  input wire logic              ZONE0_SELECT_N,
  input wire logic              ZONE6_SELECT_N,
  input wire logic              ZONE7_SELECT_N,
  input wire logic              READ_STROBE_N,
  input wire logic              WRITE_STROBE_N
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] sel;
  logic       any_sel;
  logic       tim_en;
  logic       tick;
  assign sel = ~{ZONE7_SELECT_N, ZONE6_SELECT_N, ZONE0_SELECT_N};
  assign any_sel = |sel;
  assign tim_en = PERIPH_CLK_CTRL3[PCLK_TIMCLK_BIT];
  assign tick = INTERFACE_TIMING_CLOCK;
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);
  chk_sel_onehot:
    assert property ($onehot0(sel)) else $error("two selects low");
  chk_strobe_sel:
    assert property (!(READ_STROBE_N && WRITE_STROBE_N) |-> any_sel)
      else $error("strobe without select");
  chk_zone0_reach:
    assert property (sel[0] |-> EXTERNAL_ADDRESS_BUS[19:12] == 8'h00)
      else $error("zone 0 address too high");
  chk_addr_hold:
    assert property (any_sel && $past(any_sel) |-> $stable(EXTERNAL_ADDRESS_BUS[19:1]))
      else $error("address moved in access");
  chk_tick_gated:
    assert property ((!tim_en)[*3] |-> !tick) else $error("tick while gated");
  chk_half_rate:
    assert property ((tim_en && !TIM_FULL_RATE)[*3] ##0 tick |=> !tick)
      else $error("half rate tick twice");
  chk_busclk_free:
    assert property ((!XCLK_OFF)[*2] |-> ##[0:8] $changed(EXTERNAL_BUS_CLOCK_OUT))
      else $error("bus clock stopped");
  chk_err_no_sel:
    assert property (REQ_ERROR |-> !any_sel && READ_STROBE_N && WRITE_STROBE_N)
      else $error("bus cycle on bad address");
  cov_write: cover property (!WRITE_STROBE_N);
  cov_error: cover property (REQ_ERROR);
  cov_zone7: cover property (sel[2] && !READ_STROBE_N);
endmodule

bind eaz_zone_bus eaz_zone_bus_chk #(.PCLK_W(PCLK_W)) u_chk (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .PERIPH_CLK_CTRL3(PERIPH_CLK_CTRL3),
  .TIM_FULL_RATE(TIM_FULL_RATE), .XCLK_OFF(XCLK_OFF), .REQ_ERROR(REQ_ERROR),
  .INTERFACE_TIMING_CLOCK(INTERFACE_TIMING_CLOCK),
  .EXTERNAL_BUS_CLOCK_OUT(EXTERNAL_BUS_CLOCK_OUT),
  .EXTERNAL_ADDRESS_BUS(EXTERNAL_ADDRESS_BUS), .ZONE0_SELECT_N(ZONE0_SELECT_N),
  .ZONE6_SELECT_N(ZONE6_SELECT_N), .ZONE7_SELECT_N(ZONE7_SELECT_N),
  .READ_STROBE_N(READ_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N)
);

//--- eaz_zone_bus_tb.sv
// self-checking bench for the zone bus with a memory model on the pins
// assumes one request at a time, held until its ready
module eaz_zone_bus_tb
  import eaz_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              CLOCK = 1'b0;
  logic              SYS_RST = 1'b1;
  logic [15:0]       PERIPH_CLK_CTRL3 = 16'h0000;
  logic              TIM_FULL_RATE = 1'b1, XCLK_HALF = 1'b0, XCLK_OFF = 1'b0;
  logic              PROTECT_WR_EN = 1'b0, CFG_WE = 1'b0, CPU_VALID = 1'b0, DMA_VALID = 1'b0;
  logic [1:0]        CFG_ZONE = 2'h0;
  eaz_timing_t       CFG_TIMING = TIMING_RESET;
  eaz_req_t          CPU_REQ = '0, DMA_REQ = '0;
  logic              CPU_READY, DMA_READY, RDATA_VALID, REQ_ERROR, INTERFACE_TIMING_CLOCK;
  logic              EXTERNAL_BUS_CLOCK_OUT, ZONE0_SELECT_N, ZONE6_SELECT_N, ZONE7_SELECT_N;
  logic              READ_STROBE_N, WRITE_STROBE_N, EXTERNAL_READY_INPUT, slow = 1'b0;
  logic [DATA_W-1:0] RDATA, DATA_OUT, DATA_IN, rd;
  logic [ADDR_W-1:0] EXTERNAL_ADDRESS_BUS, l_addr;
  logic [2:0]        l_sel;
  logic              err, a0w, bclk_q = 1'b0;
  logic [IADDR_W-1:0] bad [4] = '{22'h003fff, 22'h005000, 22'h0c0000, 22'h300000};
  int                n_errors = 0, check_count = 0, cyc = 0, base;
  int                sel_cnt = 0, wr_cnt = 0, rd_cnt = 0, tick_cnt = 0, tog = 0;

  eaz_zone_bus uut (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .CLK_EN(1'b1), .PERIPH_CLK_CTRL3(PERIPH_CLK_CTRL3),
    .TIM_FULL_RATE(TIM_FULL_RATE), .XCLK_HALF(XCLK_HALF), .XCLK_OFF(XCLK_OFF),
    .PROTECT_WR_EN(PROTECT_WR_EN), .CFG_WE(CFG_WE), .CFG_ZONE(CFG_ZONE),
    .CFG_TIMING(CFG_TIMING), .CPU_VALID(CPU_VALID), .CPU_REQ(CPU_REQ),
    .CPU_READY(CPU_READY), .DMA_VALID(DMA_VALID), .DMA_REQ(DMA_REQ),
    .DMA_READY(DMA_READY), .RDATA(RDATA), .RDATA_VALID(RDATA_VALID),
    .REQ_ERROR(REQ_ERROR), .BUSY(), .INTERFACE_TIMING_CLOCK(INTERFACE_TIMING_CLOCK),
    .EXTERNAL_BUS_CLOCK_OUT(EXTERNAL_BUS_CLOCK_OUT), .EXTERNAL_ADDRESS_BUS(EXTERNAL_ADDRESS_BUS),
    .ZONE0_SELECT_N(ZONE0_SELECT_N), .ZONE6_SELECT_N(ZONE6_SELECT_N),
    .ZONE7_SELECT_N(ZONE7_SELECT_N), .READ_STROBE_N(READ_STROBE_N),
    .WRITE_STROBE_N(WRITE_STROBE_N), .DATA_OUT(DATA_OUT), .DATA_OE(), .DATA_IN(DATA_IN),
    .EXTERNAL_READY_INPUT(EXTERNAL_READY_INPUT)
  );
  // pins wired to the bus function
  eaz_mem_model #(.WAIT(12)) mdl (
    .clk(CLOCK), .sel_n({ZONE7_SELECT_N, ZONE6_SELECT_N, ZONE0_SELECT_N}),
    .addr(EXTERNAL_ADDRESS_BUS), .rd_n(READ_STROBE_N), .wr_n(WRITE_STROBE_N),
    .dout(DATA_OUT), .slow(slow), .din(DATA_IN), .rdy(EXTERNAL_READY_INPUT)
  );

  initial
  begin
    forever #5 CLOCK = ~CLOCK;
  end

  task automatic complete_run();
    $display("checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // pin monitor: strobe widths, select time, last address and zone
  always @(posedge CLOCK)
  begin
    cyc <= cyc + 1;
    bclk_q <= EXTERNAL_BUS_CLOCK_OUT;
    tog <= tog + int'(bclk_q != EXTERNAL_BUS_CLOCK_OUT);
    tick_cnt <= tick_cnt + int'(INTERFACE_TIMING_CLOCK);
    wr_cnt <= wr_cnt + int'(!WRITE_STROBE_N);
    rd_cnt <= rd_cnt + int'(!READ_STROBE_N);
    if (!WRITE_STROBE_N)
      a0w <= EXTERNAL_ADDRESS_BUS[0];
    if (!(ZONE0_SELECT_N && ZONE6_SELECT_N && ZONE7_SELECT_N))
    begin
      sel_cnt <= sel_cnt + 1;
      l_sel <= {ZONE7_SELECT_N, ZONE6_SELECT_N, ZONE0_SELECT_N};
      l_addr <= EXTERNAL_ADDRESS_BUS;
    end
    if (cyc == 20000)
    begin
      n_errors++;
      complete_run();
    end
  end

  task automatic cfg(input logic [1:0] z, input logic [2:0] ra, input logic [2:0] wa,
                     input logic rdy, input logic w32, input logic prot);
    @(posedge CLOCK);
    CFG_WE <= 1'b1;
    CFG_ZONE <= z;
    PROTECT_WR_EN <= prot;
    CFG_TIMING <= '{rd: '{CNT_ONE, ra, CNT_ONE}, wr: '{CNT_ONE, wa, CNT_ONE},
                    use_ready: rdy, wide32: w32};
    @(posedge CLOCK);
    CFG_WE <= 1'b0;
    PROTECT_WR_EN <= 1'b0;
  endtask

  task automatic xfer(input logic dma, input logic [IADDR_W-1:0] a,
                      input logic [DATA_W-1:0] wd, input logic wr, input logic w32);
    int n;
    @(negedge CLOCK);
    n = 0;
    sel_cnt = 0;
    wr_cnt = 0;
    rd_cnt = 0;
    err = 1'b0;
    rd = '0;
    @(posedge CLOCK);
    CPU_REQ <= '{addr: a, wdata: wd, write: wr, wide: w32};
    DMA_REQ <= '{addr: a, wdata: wd, write: wr, wide: w32};
    CPU_VALID <= !dma;
    DMA_VALID <= dma;
    do
    begin
      @(negedge CLOCK);
      n++;
    end
    while (!(CPU_READY || DMA_READY) && n < 3000);
    chk(32'(n < 3000), 32'h1);
    @(posedge CLOCK);
    CPU_VALID <= 1'b0;
    DMA_VALID <= 1'b0;
    repeat (3)
    begin
      @(negedge CLOCK);
      if (RDATA_VALID === 1'b1)
        rd = RDATA;
      err = err | REQ_ERROR;
    end
  endtask

  initial
  begin
    repeat (5) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    repeat (20) @(posedge CLOCK);
    chk(tick_cnt, 0);
    chk(32'(tog > 4), 32'h1);
    XCLK_OFF <= 1'b1;
    repeat (6) @(posedge CLOCK);
    chk(EXTERNAL_BUS_CLOCK_OUT, 1'b0);
    XCLK_OFF <= 1'b0;
    PERIPH_CLK_CTRL3 <= 16'h1000;
    $display("test 1 done");
    // read active long enough for the data synchroniser lag
    cfg(2'h0, 3'h7, 3'h4, 1'b0, 1'b0, 1'b1);
    cfg(2'h1, 3'h7, 3'h4, 1'b0, 1'b0, 1'b1);
    cfg(2'h2, 3'h7, 3'h4, 1'b0, 1'b1, 1'b1);
    for (int r = 1; r >= 0; r--)
    begin
      @(posedge CLOCK);
      TIM_FULL_RATE <= r[0];
      XCLK_HALF <= !r[0];
      xfer(1'b0, ZONE0_BASE + 22'h000fff, 32'h1234 + r, 1'b1, 1'b0);
      // strobe spans the active ticks plus the ready-sample tick
      chk(wr_cnt, 5 * (2 - r));
      chk(l_addr, 20'h00fff);
      chk(l_sel, 3'b110);
      xfer(1'b0, ZONE0_BASE + 22'h000fff, '0, 1'b0, 1'b0);
      chk(rd_cnt, 8 * (2 - r));
      chk(rd[15:0], 32'h1234 + r);
    end
    $display("test 2 done");
    xfer(1'b1, ZONE7_BASE + 22'h000002, 32'ha5a5_5a5a, 1'b1, 1'b1);
    chk(l_sel, 3'b011);
    chk(a0w, 1'b0);
    xfer(1'b0, ZONE6_BASE + 22'h000002, 32'h1111, 1'b1, 1'b0);
    xfer(1'b0, ZONE6_BASE + 22'h0fffff, 32'h2222, 1'b1, 1'b0);
    chk(l_addr, 20'hfffff);
    chk(l_sel, 3'b101);
    chk(a0w, 1'b1);
    xfer(1'b1, ZONE7_BASE + 22'h000002, '0, 1'b0, 1'b1);
    chk(rd, 32'ha5a5_5a5a);
    $display("test 3 done");
    cfg(2'h0, 3'h1, 3'h7, 1'b0, 1'b0, 1'b0);
    xfer(1'b0, ZONE0_BASE, '0, 1'b1, 1'b0);
    chk(wr_cnt, 10);
    foreach (bad[i])
    begin
      xfer(1'b0, bad[i], '0, 1'b0, 1'b0);
      chk(err, 1'b1);
      chk(sel_cnt, 0);
    end
    $display("test 4 done");
    xfer(1'b0, ZONE6_BASE, 32'h3, 1'b1, 1'b0);
    base = sel_cnt;
    slow = 1'b1;
    xfer(1'b0, ZONE6_BASE, 32'h3, 1'b1, 1'b0);
    chk(sel_cnt, base);
    cfg(2'h1, 3'h1, 3'h4, 1'b1, 1'b0, 1'b1);
    xfer(1'b0, ZONE6_BASE, 32'h3, 1'b1, 1'b0);
    chk(32'(sel_cnt > base + 4), 32'h1);
    slow = 1'b0;
    $display("test 5 done");
    complete_run();
  end
endmodule
